// >>> core/flash_bus_host.v
`timescale 1ns/100ps
`include "flash_host_regs.vh"
module flash_bus_host #(
   parameter ADDR_W = 21,
   parameter DATA_W = 16,
   parameter WAKE_CYCLES = `WAKE_CYC
) (
   input wire sys_clk,
   input wire srst,
   input wire clk_en,
   input wire req_valid,
   input wire [2:0] req_op,
   input wire [ADDR_W-1:0] req_addr,
   input wire [DATA_W-1:0] req_wdata,
   output reg req_ready,
   output reg rsp_valid,
   output reg [DATA_W-1:0] rsp_rdata,
   output reg [4:0] rsp_block,
   output reg [ADDR_W-1:0] flash_addr,
   output reg [DATA_W-1:0] flash_dq_out,
   output reg flash_dq_oe,
   input wire [DATA_W-1:0] flash_dq_in,
   output reg chip_select_a_n,
   output reg chip_select_b_n,
   output reg output_enable_n,
   output reg write_enable_n,
   output reg reset_powerdown_n
);
   localparam [5:0] S_IDLE = 6'h01;
   localparam [5:0] S_READ = 6'h02;
   localparam [5:0] S_WRITE = 6'h04;
   localparam [5:0] S_HOLD = 6'h08;
   localparam [5:0] S_RST = 6'h10;
   localparam [5:0] S_WAKE = 6'h20;
   localparam [15:0] ACC_N = `ACCESS_CYC;
   localparam [15:0] WE_N = `WE_PULSE_CYC;
   localparam [15:0] RST_N = `RESET_LOW_CYC;
   localparam [15:0] WAKE_N = WAKE_CYCLES;

   // Sequencer states, one-hot.
   // S_IDLE waits for a request with ready high.
   // S_READ holds selects and output enable low for the access time.
   // S_WRITE holds write enable low for the pulse width.
   // S_HOLD keeps data driven one cycle past the rising write enable.
   // S_RST holds the reset/power-down pin low for its minimum time.
   // S_WAKE waits out the wake-up time before the first access.
   // S_READ, S_HOLD, S_RST and S_WAKE leave the pins idle on exit, but S_IDLE and
   // S_WRITE do not, so a frozen clock enable can leave the bus half way through a cycle.

   // Write protection, locking, suspend and the erase and program
   // algorithms all live inside the device. This block only issues
   // single bus cycles and reset pulses; the user builds every multi-step sequence from
   // them and polls status by reading after a status command.
   // A limitation: the user must not skip the array read command after an
   // alteration, since this block never issues one on its own behalf.

   reg [5:0] state_q;
   reg [15:0] cnt_q;
   reg [DATA_W-1:0] dq_s1_q;
   reg [DATA_W-1:0] dq_s2_q;

   // Data pins come from another domain, so two flops precede any use.
   // The cost is two cycles of extra read latency on every read.
   always @(posedge sys_clk) begin
      if (srst) begin
         dq_s1_q <= {DATA_W{1'b0}};
         dq_s2_q <= {DATA_W{1'b0}};
      end else if (clk_en) begin
         dq_s1_q <= flash_dq_in;
         dq_s2_q <= dq_s1_q;
      end
   end

   // Bus sequencer. Reset starts with a power-down pulse so the device is
   // known to be in array read afterwards, whatever it was doing.
   always @(posedge sys_clk) begin
      if (srst) begin
         state_q <= S_RST;
         cnt_q <= 16'h0000;
         req_ready <= 1'b0;
         rsp_valid <= 1'b0;
         rsp_rdata <= {DATA_W{1'b0}};
         rsp_block <= 5'h00;
         flash_addr <= {ADDR_W{1'b0}};
         flash_dq_out <= {DATA_W{1'b0}};
         flash_dq_oe <= 1'b0;
         chip_select_a_n <= 1'b1;
         chip_select_b_n <= 1'b1;
         output_enable_n <= 1'b1;
         write_enable_n <= 1'b1;
         reset_powerdown_n <= 1'b0;
      end else if (clk_en) begin
         rsp_valid <= 1'b0;
         case (state_q)
            S_IDLE: begin
               if (req_valid && req_ready) begin
                  req_ready <= 1'b0;
                  flash_addr <= req_addr;
                  // Each block is 64 KB, so the field names one of 32.
                  rsp_block <= req_addr[`BLOCK_MSB:`BLOCK_LSB];
                  // The full address goes out, top block at the top. 
                  cnt_q <= 16'h0000;
                  if (req_op == `OP_WRITE) begin
                     // Commands and data go through the command port.
                     // One request is one bus cycle, so a stray single
                     // write cannot stand in for a whole sequence.
                     // Lock, suspend and resume commands pass unchanged.
                     // The device runs its own algorithm after the last
                     // cycle; the host only polls status afterwards.
                     flash_dq_out <= req_wdata;
                     flash_dq_oe <= 1'b1;
                     chip_select_a_n <= 1'b0;
                     chip_select_b_n <= 1'b0;
                     write_enable_n <= 1'b0;
                     state_q <= S_WRITE;
                  end else if (req_op == `OP_RESET) begin
                     reset_powerdown_n <= 1'b0;
                     state_q <= S_RST;
                  end else begin
                     // Source is whatever the last mode command chose.
                     // No read depends on the program supply level.
                     chip_select_a_n <= 1'b0;
                     chip_select_b_n <= 1'b0;
                     output_enable_n <= 1'b0;
                     state_q <= S_READ;
                  end
               end
            end
            S_READ: begin
               if (cnt_q == ACC_N + 16'h0002) begin
                  // Two extra cycles cover the pin synchroniser delay.
                  rsp_rdata <= dq_s2_q;
                  rsp_valid <= 1'b1;
                  chip_select_a_n <= 1'b1;
                  chip_select_b_n <= 1'b1;
                  output_enable_n <= 1'b1;
                  req_ready <= 1'b1;
                  state_q <= S_IDLE;
               end else begin
                  cnt_q <= cnt_q + 16'h0001;
               end
            end
            S_WRITE: begin
               if (cnt_q == WE_N - 16'h0001) begin
                  // Rising write enable latches address and data.
                  write_enable_n <= 1'b1;
                  state_q <= S_HOLD;
               end else begin
                  cnt_q <= cnt_q + 16'h0001;
               end
            end
            S_HOLD: begin
               // Data held one cycle past the latch edge, then released.
               flash_dq_oe <= 1'b0;
               chip_select_a_n <= 1'b1;
               chip_select_b_n <= 1'b1;
               rsp_valid <= 1'b1;
               req_ready <= 1'b1;
               state_q <= S_IDLE;
            end
            S_RST: begin
               if (cnt_q >= RST_N - 16'h0001) begin
                  reset_powerdown_n <= 1'b1;
                  cnt_q <= 16'h0000;
                  state_q <= S_WAKE;
               end else begin
                  cnt_q <= cnt_q + 16'h0001;
               end
            end
            // No access may start before the device has woken, as its
            // outputs are not valid until then.
            S_WAKE: begin
               if (cnt_q >= WAKE_N - 16'h0001) begin
                  rsp_valid <= 1'b1;
                  req_ready <= 1'b1;
                  state_q <= S_IDLE;
               end else begin
                  cnt_q <= cnt_q + 16'h0001;
               end
            end
            default: begin
               state_q <= S_RST;
               cnt_q <= 16'h0000;
            end
         endcase
      end
   end
endmodule // flash_bus_host

// >>> core/flash_host_regs.vh
`ifndef FLASH_HOST_REGS_VH
`define FLASH_HOST_REGS_VH
// Operation codes on the user request port.
`define OP_READ 3'h0
`define OP_WRITE 3'h1
`define OP_RESET 3'h2
// Block field: bits 20..16 of the byte address select one of 32 blocks.
`define BLOCK_LSB 16
`define BLOCK_MSB 20
`define BLOCK_LAST 5'h1F
// Timing in ns, and the same spans in cycles of the 5 ns clock.
// The cycle counts are sized to the 16-bit counter they are compared with.
`define CLK_PERIOD_NS 5
`define ACCESS_NS 100
`define ACCESS_CYC 16'h0014
`define WE_PULSE_NS 50
`define WE_PULSE_CYC 16'h000A
`define RESET_LOW_NS 100
`define RESET_LOW_CYC 16'h0014
`define WAKE_NS 1000
`define WAKE_CYC 16'h00C8
`endif

// >>> verif/flash_host_chk_assertions.sv
`timescale 1ns/100ps
module flash_host_chk(
   input wire sys_clk, srst, clk_en, req_valid, req_ready, rsp_valid,
   input wire [2:0] req_op,
   input wire chip_select_a_n, chip_select_b_n, output_enable_n,
   input wire write_enable_n, reset_powerdown_n, flash_dq_oe);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (srst);
   // A request is taken only at an enabled edge with ready high.
   wire take = req_valid && req_ready && clk_en;
   property p_rd; !output_enable_n |-> !chip_select_a_n &&
      !chip_select_b_n && write_enable_n && reset_powerdown_n; endproperty
   property p_oe; flash_dq_oe |-> output_enable_n; endproperty
   property p_we; !write_enable_n |-> flash_dq_oe && !chip_select_a_n;
   endproperty
   property p_weh; $rose(write_enable_n) |-> $past(flash_dq_oe);
   endproperty
   property p_tk; take |=> !req_ready; endproperty
   property p_rl; take && req_op == 3'h0 |-> ##[23:24] rsp_valid; endproperty
   property p_wl; take && req_op == 3'h1 |-> ##[11:12] rsp_valid; endproperty
   property p_rp; $fell(reset_powerdown_n) |-> !reset_powerdown_n[*8];
   endproperty
   a_rd: assert property (p_rd) else $error("read strobes");
   a_oe: assert property (p_oe) else $error("bus clash");
   a_we: assert property (p_we) else $error("write strobes");
   a_weh: assert property (p_weh) else $error("data dropped");
   a_tk: assert property (p_tk) else $error("ready held");
   a_rl: assert property (p_rl) else $error("read latency");
   a_wl: assert property (p_wl) else $error("write latency");
   a_rp: assert property (p_rp) else $error("short reset");
   c_rd: cover property (take && req_op == 3'h0);
   c_wr: cover property (take && req_op == 3'h1);
   c_rp: cover property (take && req_op == 3'h2);
endmodule // flash_host_chk
bind flash_bus_host flash_host_chk i_chk(.sys_clk, .srst, .clk_en,
   .req_valid, .req_ready, .rsp_valid, .req_op, .chip_select_a_n,
   .chip_select_b_n, .output_enable_n, .write_enable_n,
   .reset_powerdown_n, .flash_dq_oe);

// >>> verif/flash_model.sv
`timescale 1ns/100ps
module flash_model #(parameter logic [15:0] ID_CODE = 16'h00A1)(
   input wire sys_clk, input wire [20:0] addr, input wire [15:0] din,
   output logic [15:0] dout, input wire cs_a_n, cs_b_n, oe_n, we_n, rp_n);
   logic [15:0] mem [int];
   logic [1:0] mode = 2'h0;
   logic prog = 1'b0, flip = 1'b0;
   wire sel = !cs_a_n && !cs_b_n && rp_n;
   // Power-down clears any half-entered sequence too.
   always @(negedge rp_n) begin mode = 2'h0; prog = 1'b0; end
   // Address and data latch at the write strobe's rising edge.
   always @(posedge we_n) if (sel) begin
      if (prog) begin mem[addr] = din; prog = 0; mode = 2'h1; end
      else case (din) 16'h00FF: mode = 2'h0; 16'h0070: mode = 2'h1;
         16'h0090: mode = 2'h2; 16'h0098: mode = 2'h3;
         16'h0040: prog = 1'b1; default: ; endcase
   end
   always @(posedge sys_clk) flip <= ~flip;
   // A released bus toggles so that a stale sample cannot pass.
   always @* if (sel && !oe_n) case (mode)
      2'h0: dout = mem.exists(addr) ? mem[addr] : 16'hFFFF;
      2'h1: dout = 16'h0080; 2'h2: dout = ID_CODE; default: dout = 16'h0051;
   endcase else dout = flip ? 16'h5A5A : 16'hA5A5;
endmodule // flash_model

// >>> verif/tb.sv
`timescale 1ns/100ps
module tb;
   localparam logic [15:0] ID = 16'h00A1; // Arbitrary value.
   logic sys_clk = 0, srst = 1, req_valid = 0;
   logic [2:0] req_op = 3'h0;
   logic [20:0] req_addr = 21'h0;
   logic [15:0] req_wdata = 16'h0, rd;
   wire req_ready, rsp_valid, dq_oe, cs_a_n, cs_b_n, oe_n, we_n, rp_n;
   wire [15:0] rsp_rdata, dq_out, dq_in;
   wire [4:0] rsp_block;
   wire [20:0] fa;
   int fails = 0, check_count = 0;
   initial forever #2.5 sys_clk = ~sys_clk;
   flash_bus_host #(.WAKE_CYCLES(16'h0002)) i_dut(.sys_clk, .srst,
      .clk_en(1'b1),
      .req_valid, .req_op, .req_addr, .req_wdata, .req_ready, .rsp_valid,
      .rsp_rdata, .rsp_block, .flash_addr(fa), .flash_dq_out(dq_out),
      .flash_dq_oe(dq_oe), .flash_dq_in(dq_in), .chip_select_a_n(cs_a_n),
      .chip_select_b_n(cs_b_n), .output_enable_n(oe_n),
      .write_enable_n(we_n), .reset_powerdown_n(rp_n));
   flash_model #(.ID_CODE(ID)) i_mem(.sys_clk, .addr(fa), .din(dq_out),
      .dout(dq_in), .cs_a_n, .cs_b_n, .oe_n, .we_n, .rp_n);
   task chk(input logic [15:0] e, g);
      check_count++;
      if (g !== e) begin
         fails++;
         $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask
   // Inputs move at falling edges, so the rising edge sees them settled.
   task xf(input logic [2:0] o, input logic [20:0] a, input logic [15:0] d);
      int n;
      @(negedge sys_clk);
      {req_op, req_addr, req_wdata, req_valid} = {o, a, d, 1'b1};
      while (!req_ready) @(negedge sys_clk);
      @(negedge sys_clk);
      req_valid = 0;
      for (n = 0; n < 99 && rsp_valid !== 1'b1; n++) @(negedge sys_clk);
      if (n == 99) fails++;
      rd = rsp_rdata;
   endtask
   task t_prog;
      xf(3'h0, 21'h000010, 16'h0); chk(16'hFFFF, rd);
      xf(3'h1, 21'h000020, 16'h1234); // A lone write alters nothing.
      xf(3'h0, 21'h000020, 16'h0); chk(16'hFFFF, rd);
      xf(3'h1, 21'h1F0004, 16'h0040); xf(3'h1, 21'h1F0004, 16'h1234);
      chk(16'h001F, {11'h0, rsp_block});
      xf(3'h1, 21'h0, 16'h00FF); xf(3'h0, 21'h1F0004, 16'h0);
      chk(16'h1234, rd);
      $display("prog test done");
   endtask
   task t_modes;
      logic [15:0] c [4] = '{16'h0070, 16'h0090, 16'h0098, 16'h00FF};
      logic [15:0] e [4] = '{16'h0080, ID, 16'h0051, 16'h1234};
      for (int i = 0; i < 4; i++) begin
         xf(3'h1, 21'h0, c[i]); xf(3'h0, 21'h1F0004, 16'h0);
         chk(e[i], rd);
      end
      xf(3'h1, 21'h0, 16'h0070); xf(3'h2, 21'h0, 16'h0);
      xf(3'h0, 21'h1F0004, 16'h0); chk(16'h1234, rd);
      $display("mode test done");
   endtask
   task wrap_up;
      $display("checks=%0d fails=%0d", check_count, fails);
      if (fails == 0 && check_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      repeat (5) @(negedge sys_clk);
      srst = 0;
      t_prog;
      t_modes;
      wrap_up;
   end
   // The tests need about 400 cycles, so 20 us means a hang.
   initial begin #20000; fails++; wrap_up; end
endmodule // tb
